/* File: src/lbc_pkg.sv */
// Shared constants and types of the chip-select local bus controller.
// Assumes registers are addressed by a 12-bit offset from the module base.
package lbc_pkg;

  localparam int NUM_SEL = 6;
  localparam int ADDR_W = 25;
  localparam int REG_ADDR_W = 12;

  // Register offsets from the module base
  localparam logic [11:0] BLOCK_OFS = 12'h300;
  localparam logic [11:0] OFS_BOOT = 12'h300;
  localparam logic [11:0] OFS_CFG_FIRST = 12'h304;
  localparam logic [11:0] OFS_CFG_LAST = 12'h314;
  localparam logic [11:0] OFS_CONTROL = 12'h318;
  localparam logic [11:0] OFS_STATUS = 12'h31c;
  localparam logic [2:0] IDX_CONTROL = 3'h6;
  localparam logic [2:0] IDX_STATUS = 3'h7;

  // Select configuration fields (bit 0 is the least significant bit)
  localparam int F_WAIT_PRESCALE_LSB = 24;
  localparam int F_WAITX_LSB = 16;
  localparam int B_MUX = 15;
  localparam int B_LATCH_LEN = 14;
  localparam int B_ACK_ACTIVE = 13;
  localparam int B_SEL_ENABLE = 12;
  localparam int F_AS_LSB = 10;
  localparam int F_DS_LSB = 8;
  localparam int F_BANK_LSB = 6;
  localparam int F_KIND_LSB = 4;
  localparam int B_WSWAP = 3;
  localparam int B_RSWAP = 2;
  localparam int B_WONLY = 1;
  localparam int B_RONLY = 0;
  localparam int BANK_AD_LSB = 25;

  // Control register fields
  localparam int B_EXT_FAULT = 31;
  localparam int B_REG_FAULT = 28;
  localparam int B_IRQ_UNUSED = 27;
  localparam int B_GLOBAL_EN = 24;
  localparam logic [31:0] CONTROL_WMASK = 32'h9900_0000;

  // Status register fields
  localparam int B_WRONLY_VIOL = 29;
  localparam int B_RDONLY_VIOL = 28;
  localparam int F_VSEL_LSB = 24;
  localparam int B_BAD_WR = 17;
  localparam int B_BAD_RD = 16;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Field encodings
  localparam logic [1:0] SIZE_1 = 2'h0;
  localparam logic [1:0] SIZE_2 = 2'h1;
  localparam logic [1:0] SIZE_4 = 2'h3;
  localparam logic [1:0] AS_8 = 2'h0;
  localparam logic [1:0] AS_16 = 2'h1;
  localparam logic [1:0] AS_24 = 2'h2;
  localparam logic [24:0] MASK_8 = 25'h000_00ff;
  localparam logic [24:0] MASK_16 = 25'h000_ffff;
  localparam logic [24:0] MASK_24 = 25'h0ff_ffff;
  localparam logic [24:0] MASK_25 = 25'h1ff_ffff;
  localparam logic [1:0] KIND_BASE = 2'h0;
  localparam logic [1:0] KIND_PRESCALE_WR = 2'h1;
  localparam logic [1:0] KIND_COMBINED = 2'h3;
  localparam logic [1:0] LATCH_ONE = 2'h1;
  localparam logic [1:0] LATCH_TWO = 2'h2;
  localparam logic [15:0] WAIT_MIN = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LATCH = 3'b010,
    ST_WAIT = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic [NUM_SEL-1:0][31:0] cfg;
    logic [31:0] control;
    logic [31:0] status;
    logic [31:0] reg_rdata;
    logic reg_ack;
    logic reg_err;
    bus_state_t st;
    logic [31:0] cur;
    logic [31:0] cur_wdata;
    logic [NUM_SEL-1:0] cur_sel_mask;
    logic cur_wr;
    logic [1:0] cur_size;
    logic [15:0] wait_cnt;
    logic [1:0] latch_cnt;
    logic [31:0] ad_out;
    logic ad_oe;
    logic [ADDR_W-1:0] ext_addr;
    logic latch_strobe_n;
    logic [NUM_SEL-1:0] select_line_n;
    logic rd_n;
    logic wr_n;
    logic [31:0] acc_rdata;
    logic acc_done;
    logic acc_err;
  } ctrl_state_t;

endpackage : lbc_pkg

/* File: src/swap_if.sv */
// Connection between the controller and a byte-order unit.
// Assumes both ends sit in the same clock domain; the unit is combinational.
`timescale 1ns/1ps
`default_nettype none
interface swap_if;
  logic [31:0] data_in;
  logic [1:0] size;
  logic [1:0] port_size;
  logic enable;
  logic [31:0] data_out;
  modport unit (input data_in, input size, input port_size, input enable,
    output data_out);
  modport user (output data_in, output size, output port_size,
    output enable, input data_out);
endinterface : swap_if
`default_nettype wire

/* File: src/byte_swap.sv */
// Byte-order reversal sized by the current transaction.
// Assumes size codes from lbc_pkg; no state.
`timescale 1ns/1ps
`default_nettype none
module byte_swap
  import lbc_pkg::*;
(
  swap_if.unit sw
);
  always_comb begin
    sw.data_out = sw.data_in;
    // Byte-wide peripherals are never swapped
    if (sw.enable && sw.port_size != SIZE_1) begin
      case (sw.size)
        SIZE_2: sw.data_out = {sw.data_in[31:16], sw.data_in[7:0],
          sw.data_in[15:8]};
        SIZE_4: sw.data_out = {sw.data_in[7:0], sw.data_in[15:8],
          sw.data_in[23:16], sw.data_in[31:24]};
        default: sw.data_out = sw.data_in;
      endcase
    end
  end
endmodule : byte_swap
`default_nettype wire

/* File: src/pin_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes d is asynchronous to clk; q changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.q = s.s3;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= {4{RST}};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule : pin_sync
`default_nettype wire

/* File: src/chip_select_local_bus_ctrl.sv */
// Chip-select controller for ROM, SRAM and flash on the local bus.
// Assumes one clock; register and access ports come from on-chip logic on clk.
`timescale 1ns/1ps
`default_nettype none
module chip_select_local_bus_ctrl
  import lbc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [2:0] acc_sel,
  input wire logic [1:0] acc_size,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  output logic [31:0] acc_rdata,
  output logic acc_done,
  output logic acc_err,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic [ADDR_W-1:0] ext_addr,
  output logic latch_strobe_n,
  output logic [NUM_SEL-1:0] select_line_n,
  output logic rd_n,
  output logic wr_n,
  input wire logic ack_n
);
  ctrl_state_t s;
  ctrl_state_t next_s;
  logic [31:0] ad_in_sync;
  logic ack_n_sync;

  swap_if wsw ();
  swap_if rsw ();

  pin_sync #(.W(32), .RST(32'h0000_0000)) u_ad_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(ad_in),
    .q(ad_in_sync)
  );

  pin_sync #(.W(1), .RST(1'b1)) u_ack_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(ack_n),
    .q(ack_n_sync)
  );

  byte_swap u_wr_swap (.sw(wsw.unit));
  byte_swap u_rd_swap (.sw(rsw.unit));

  logic [31:0] req_cfg;
  assign req_cfg = (acc_sel < 3'(NUM_SEL)) ? s.cfg[acc_sel] : REG_RESET;

  // Write data swapped as it is accepted
  assign wsw.data_in = acc_wdata;
  assign wsw.size = acc_size;
  assign wsw.port_size = req_cfg[F_DS_LSB +: 2];
  assign wsw.enable = req_cfg[B_WSWAP];
  // Read data swapped as it is captured
  assign rsw.data_in = ad_in_sync;
  assign rsw.size = s.cur_size;
  assign rsw.port_size = s.cur[F_DS_LSB +: 2];
  assign rsw.enable = s.cur[B_RSWAP];

  always_comb begin
    logic reg_hit;
    logic [2:0] idx;
    logic sel_en;
    logic denied;
    logic [7:0] wp;
    logic [7:0] wx;
    logic [1:0] kind;
    logic [15:0] wcount;
    logic [24:0] amask;
    logic early_end;
    reg_hit = 1'b0;
    idx = 3'h0;
    sel_en = 1'b0;
    denied = 1'b0;
    wp = req_cfg[F_WAIT_PRESCALE_LSB +: 8];
    wx = req_cfg[F_WAITX_LSB +: 8];
    kind = req_cfg[F_KIND_LSB +: 2];
    wcount = WAIT_MIN;
    amask = MASK_25;
    early_end = 1'b0;
    next_s = s;
    next_s.reg_ack = 1'b0;
    next_s.reg_err = 1'b0;
    next_s.acc_done = 1'b0;
    next_s.acc_err = 1'b0;

    // Register port: one answer per request, next cycle
    reg_hit = reg_addr[11:5] == BLOCK_OFS[11:5] &&
      reg_addr[1:0] == 2'h0;
    idx = reg_addr[4:2];
    if (reg_req && !s.reg_ack && !s.reg_err) begin
      if (reg_hit) begin
        next_s.reg_ack = 1'b1;
        if (reg_write) begin
          if (idx < 3'(NUM_SEL)) begin
            next_s.cfg[idx] = reg_wdata;
          end else if (idx == IDX_CONTROL) begin
            // Interrupt enable is storage only
            next_s.control = reg_wdata & CONTROL_WMASK;
          end else begin
            next_s.status[B_WRONLY_VIOL] = s.status[B_WRONLY_VIOL] &
              ~reg_wdata[B_WRONLY_VIOL];
            next_s.status[B_RDONLY_VIOL] = s.status[B_RDONLY_VIOL] &
              ~reg_wdata[B_RDONLY_VIOL];
            next_s.status[B_BAD_WR] = s.status[B_BAD_WR] &
              ~reg_wdata[B_BAD_WR];
            next_s.status[B_BAD_RD] = s.status[B_BAD_RD] &
              ~reg_wdata[B_BAD_RD];
          end
        end else begin
          if (idx < 3'(NUM_SEL)) begin
            next_s.reg_rdata = s.cfg[idx];
          end else if (idx == IDX_CONTROL) begin
            next_s.reg_rdata = s.control;
          end else begin
            next_s.reg_rdata = s.status;
          end
        end
      end else begin
        // Unimplemented register: flag it, alter nothing else
        next_s.reg_rdata = REG_RESET;
        if (s.control[B_REG_FAULT]) begin
          next_s.reg_err = 1'b1;
        end else begin
          next_s.reg_ack = 1'b1;
        end
        if (reg_write) begin
          next_s.status[B_BAD_WR] = 1'b1;
        end else begin
          next_s.status[B_BAD_RD] = 1'b1;
        end
      end
    end

    // Wait count by direction and kind
    if (acc_write) begin
      case (kind)
        KIND_BASE: wcount = {8'h00, wx};
        KIND_PRESCALE_WR: wcount = {8'h00, wp};
        default: wcount = {wp, wx};
      endcase
    end else begin
      wcount = (kind == KIND_COMBINED) ? {wp, wx} : {8'h00, wx};
    end
    if (wcount == 16'h0000) begin
      wcount = WAIT_MIN;
    end

    case (req_cfg[F_AS_LSB +: 2])
      AS_8: amask = MASK_8;
      AS_16: amask = MASK_16;
      AS_24: amask = MASK_24;
      default: amask = MASK_25;
    endcase

    sel_en = req_cfg[B_SEL_ENABLE] &&
      (s.control[B_GLOBAL_EN] || acc_sel == 3'h0);
    denied = (acc_write && req_cfg[B_RONLY]) ||
      (!acc_write && req_cfg[B_WONLY]);
    early_end = s.cur[B_MUX] && s.cur[B_ACK_ACTIVE] && !ack_n_sync;

    case (s.st)
      ST_IDLE: begin
        if (acc_req && !s.acc_done && !s.acc_err) begin
          if (denied) begin
            // No peripheral cycle for a denied access
            next_s.acc_err = s.control[B_EXT_FAULT];
            next_s.acc_done = !s.control[B_EXT_FAULT];
            next_s.acc_rdata = REG_RESET;
            if (acc_write) begin
              next_s.status[B_RDONLY_VIOL] = 1'b1;
            end else begin
              next_s.status[B_WRONLY_VIOL] = 1'b1;
            end
            next_s.status[F_VSEL_LSB +: 3] = acc_sel;
          end else if (!sel_en) begin
            next_s.acc_done = 1'b1;
            next_s.acc_rdata = REG_RESET;
          end else begin
            next_s.cur = req_cfg;
            next_s.cur_wr = acc_write;
            next_s.cur_size = acc_size;
            next_s.wait_cnt = wcount;
            next_s.select_line_n = {NUM_SEL{1'b1}};
            if (req_cfg[B_MUX]) begin
              next_s.st = ST_LATCH;
              next_s.latch_strobe_n = 1'b0;
              next_s.latch_cnt = req_cfg[B_LATCH_LEN] ? LATCH_TWO
                : LATCH_ONE;
              next_s.ext_addr = acc_addr;
              next_s.ad_out = REG_RESET;
              next_s.ad_out[ADDR_W-1:0] = acc_addr;
              next_s.ad_out[BANK_AD_LSB +: 2] =
                req_cfg[F_BANK_LSB +: 2];
              next_s.ad_oe = 1'b1;
            end else begin
              next_s.st = ST_WAIT;
              next_s.ext_addr = acc_addr & amask;
              next_s.select_line_n[acc_sel] = 1'b0;
              next_s.rd_n = acc_write;
              next_s.wr_n = !acc_write;
              next_s.ad_out = wsw.data_out;
              next_s.ad_oe = acc_write;
            end
            next_s.cur_wdata = wsw.data_out;
            next_s.cur_sel_mask = {NUM_SEL{1'b1}};
            next_s.cur_sel_mask[acc_sel] = 1'b0;
          end
        end
      end
      ST_LATCH: begin
        if (s.latch_cnt == LATCH_ONE) begin
          // End of strobe: bus turns to data and select goes active
          next_s.st = ST_WAIT;
          next_s.latch_strobe_n = 1'b1;
          next_s.select_line_n = s.cur_sel_mask;
          next_s.rd_n = s.cur_wr;
          next_s.wr_n = !s.cur_wr;
          next_s.ad_out = s.cur_wdata;
          next_s.ad_oe = s.cur_wr;
        end else begin
          next_s.latch_cnt = s.latch_cnt - LATCH_ONE;
        end
      end
      ST_WAIT: begin
        if (s.wait_cnt == WAIT_MIN || early_end) begin
          next_s.st = ST_IDLE;
          next_s.select_line_n = {NUM_SEL{1'b1}};
          next_s.rd_n = 1'b1;
          next_s.wr_n = 1'b1;
          next_s.ad_oe = 1'b0;
          next_s.acc_done = 1'b1;
          next_s.acc_rdata = s.cur_wr ? REG_RESET : rsw.data_out;
        end else begin
          next_s.wait_cnt = s.wait_cnt - WAIT_MIN;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.select_line_n = {NUM_SEL{1'b1}};
        next_s.latch_strobe_n = 1'b1;
        next_s.rd_n = 1'b1;
        next_s.wr_n = 1'b1;
        next_s.ad_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.latch_strobe_n <= 1'b1;
      s.select_line_n <= {NUM_SEL{1'b1}};
      s.rd_n <= 1'b1;
      s.wr_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.reg_rdata;
  assign reg_ack = s.reg_ack;
  assign reg_err = s.reg_err;
  assign acc_rdata = s.acc_rdata;
  assign acc_done = s.acc_done;
  assign acc_err = s.acc_err;
  assign ad_out = s.ad_out;
  assign ad_oe = s.ad_oe;
  assign ext_addr = s.ext_addr;
  assign latch_strobe_n = s.latch_strobe_n;
  assign select_line_n = s.select_line_n;
  assign rd_n = s.rd_n;
  assign wr_n = s.wr_n;
endmodule : chip_select_local_bus_ctrl
`default_nettype wire

/* File: verification/lbc_props.sv */
// Port-level checks of the chip-select controller.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module lbc_props
  import lbc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_req,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic acc_req,
  input wire logic acc_done,
  input wire logic acc_err,
  input wire logic ad_oe,
  input wire logic latch_strobe_n,
  input wire logic [NUM_SEL-1:0] select_line_n,
  input wire logic rd_n,
  input wire logic wr_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  reg_answer_a: assert property (reg_req && !reg_ack && !reg_err |=>
    reg_ack != reg_err) else $error("register request not answered");
  acc_answer_a: assert property ((acc_done || acc_err) |->
    $past(acc_req) && !(acc_done && acc_err)) else $error("bad answer");
  one_select_a: assert property ($onehot0(~select_line_n))
    else $error("two selects active");
  latch_width_a: assert property ($fell(latch_strobe_n) |=> ##[0:1]
    latch_strobe_n) else $error("latch strobe too long");
  addr_tenure_a: assert property (!latch_strobe_n |->
    ad_oe && (&select_line_n)) else $error("address tenure wrong");
  data_tenure_a: assert property ($rose(latch_strobe_n) |-> ##[0:1]
    !(&select_line_n)) else $error("no select after latch");
  strobe_select_a: assert property ((!rd_n || !wr_n) |->
    !(&select_line_n)) else $error("strobe without select");
  done_release_a: assert property ($rose(&select_line_n) |->
    acc_done) else $error("select released without done");
  write_drive_a: assert property (!wr_n |-> ad_oe)
    else $error("write data not driven");
  denied_quiet_a: assert property (acc_err |->
    (&select_line_n) && rd_n && wr_n) else $error("denied access moved");
endmodule : lbc_props
bind chip_select_local_bus_ctrl lbc_props lbc_props_i (.clk(clk),
  .arst_n(arst_n), .reg_req(reg_req), .reg_ack(reg_ack),
  .reg_err(reg_err), .acc_req(acc_req), .acc_done(acc_done),
  .acc_err(acc_err), .ad_oe(ad_oe), .latch_strobe_n(latch_strobe_n),
  .select_line_n(select_line_n), .rd_n(rd_n), .wr_n(wr_n));
`default_nettype wire

/* File: verification/bus_peripheral.sv */
// Behavioural ROM/SRAM peripheral on the local bus.
// Assumes active-low pins; released data lines toggle, acknowledge pulls up.
`timescale 1ns/1ps
`default_nettype none
module bus_peripheral (
  input wire logic clk,
  input wire logic [5:0] select_line_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic latch_strobe_n,
  input wire logic [31:0] ad_out,
  input wire logic [31:0] rd_word,
  input wire logic [7:0] ack_after,
  output logic [31:0] ad_in,
  output logic ack_n,
  output logic [31:0] wr_seen,
  output logic [31:0] latch_seen
);
  logic [7:0] low_cnt;
  initial begin
    low_cnt = 8'h00;
    ad_in = 32'h0000_0000;
    ack_n = 1'b1;
    wr_seen = 32'h0000_0000;
    latch_seen = 32'h0000_0000;
  end
  always @(posedge clk) begin
    low_cnt <= (&select_line_n) ? 8'h00 : low_cnt + 8'h01;
    ad_in <= (!rd_n && !(&select_line_n)) ? rd_word : ~ad_in;
    ack_n <= !(!(&select_line_n) && ack_after != 8'h00 &&
      low_cnt >= ack_after);
    if (!wr_n) wr_seen <= ad_out;
    if (!latch_strobe_n) latch_seen <= ad_out;
  end
endmodule : bus_peripheral
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the chip-select controller and peripheral model.
// Assumes lbc_pkg field positions and the hand-over port timing.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lbc_pkg::*;
  logic clk = 1'b0;
  logic arst_n, reg_req, reg_write, reg_ack, reg_err, acc_req, acc_write;
  logic acc_done, acc_err, ad_oe, latch_strobe_n, rd_n, wr_n, ack_n, a_e;
  logic [11:0] reg_addr;
  logic [2:0] acc_sel, s;
  logic [1:0] acc_size, z;
  logic [24:0] acc_addr, ext_addr, a_ext;
  logic [31:0] reg_wdata, reg_rdata, acc_wdata, acc_rdata, ad_in, ad_out;
  logic [31:0] rd_word, wr_seen, latch_seen, seed, a_q, r, d, e;
  logic [NUM_SEL-1:0] select_line_n;
  logic [7:0] ack_after, p, x;
  int failures, checks, a_lo, a_ls;
  always #4 clk = ~clk;
  chip_select_local_bus_ctrl chip_select_local_bus_ctrl_i (.clk(clk),
    .arst_n(arst_n), .reg_req(reg_req), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .acc_req(acc_req),
    .acc_write(acc_write), .acc_sel(acc_sel), .acc_size(acc_size),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_done(acc_done), .acc_err(acc_err), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .ext_addr(ext_addr), .latch_strobe_n(latch_strobe_n),
    .select_line_n(select_line_n), .rd_n(rd_n), .wr_n(wr_n), .ack_n(ack_n));
  bus_peripheral bus_peripheral_i (.clk(clk), .select_line_n(select_line_n),
    .rd_n(rd_n), .wr_n(wr_n), .latch_strobe_n(latch_strobe_n),
    .ad_out(ad_out), .rd_word(rd_word), .ack_after(ack_after), .ad_in(ad_in),
    .ack_n(ack_n), .wr_seen(wr_seen), .latch_seen(latch_seen));

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] v,
    input logic [31:0] g);
    checks++;
    if (g !== v) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, v, g);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] wexp(input logic [1:0] k, input logic w,
    input logic [7:0] wp, input logic [7:0] wx);
    logic [15:0] v;
    v = {8'h00, wx};
    if (k == KIND_COMBINED || (w && k == 2'h2)) v = {wp, wx};
    if (w && k == KIND_PRESCALE_WR) v = {8'h00, wp};
    return (v == 16'h0000) ? 32'h0000_0001 : {16'h0000, v};
  endfunction : wexp
  function automatic logic [31:0] bsw(input logic [31:0] v,
    input logic [1:0] k);
    if (k == SIZE_2) return {16'h0000, v[7:0], v[15:8]};
    if (k == SIZE_4) return {v[7:0], v[15:8], v[23:16], v[31:24]};
    return {24'h00_0000, v[7:0]};
  endfunction : bsw
  function automatic logic [24:0] amask(input logic [1:0] a);
    if (a == AS_8) return MASK_8;
    if (a == AS_16) return MASK_16;
    if (a == AS_24) return MASK_24;
    return MASK_25;
  endfunction : amask
  task automatic reg_op(input logic w, input logic [11:0] a,
    input logic [31:0] v);
    int n;
    reg_req <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(reg_ack || reg_err) && n < 9);
    chk("reg answer", 32'h0000_0001, {31'h0, reg_ack ^ reg_err});
    a_q = reg_rdata;
    a_e = reg_err;
    reg_req <= 1'b0;
    @(posedge clk);
  endtask : reg_op
  task automatic reg_c(input logic [11:0] a, input logic [31:0] v);
    reg_op(1'b0, a, 32'h0000_0000);
    chk("register", v, a_q);
  endtask : reg_c
  task automatic cfg(input logic [2:0] k, input logic [31:0] v);
    reg_op(1'b1, OFS_BOOT + {7'h00, k, 2'h0}, v);
  endtask : cfg
  task automatic acc(input logic w, input logic [2:0] k, input logic [1:0] sz);
    int n;
    acc_req <= 1'b1;
    acc_write <= w;
    acc_sel <= k;
    acc_size <= sz;
    acc_addr <= r[24:0];
    acc_wdata <= d;
    a_lo = 0;
    a_ls = 0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (!(&select_line_n)) begin
        a_lo++;
        a_ext = ext_addr;
      end
      if (!latch_strobe_n) a_ls++;
    end while (!(acc_done || acc_err) && n < 1200);
    chk("acc answer", 32'h0000_0001, {31'h0, acc_done ^ acc_err});
    a_q = acc_rdata;
    a_e = acc_err;
    acc_req <= 1'b0;
    @(posedge clk);
  endtask : acc

  // Watchdog: the full sequence needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    seed = 32'h0000_001f;
    {arst_n, reg_req, reg_write, acc_req, acc_write} = 5'h00;
    {reg_addr, reg_wdata, acc_sel, acc_size} = 49'h0;
    {acc_addr, acc_wdata, rd_word, ack_after} = 97'h0;
    failures = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      reg_c(OFS_BOOT + 12'(4 * i), REG_RESET);
    end
    r = rnd();
    d = rnd();
    acc(1'b0, 3'h0, SIZE_1);
    chk("boot off span", 32'h0000_0000, 32'(a_lo));
    reg_op(1'b1, OFS_CONTROL, 32'hffff_ffff);
    reg_c(OFS_CONTROL, CONTROL_WMASK);
    reg_op(1'b1, OFS_CONTROL, 32'h0900_0000);
    for (int k = 0; k < 4; k++) begin
      for (int w = 0; w < 2; w++) begin
        e = rnd();
        p = (k == 1) ? 8'h00 : {6'h00, e[25:24]};
        x = {5'h00, e[18:16]};
        cfg(3'(k + 1), {p, x, 4'h1, k[1:0], SIZE_2, 2'h0, k[1:0], 4'h0});
        r = rnd();
        d = rnd();
        acc(w[0], 3'(k + 1), SIZE_2);
        chk("wait span", wexp(k[1:0], w[0], p, x), 32'(a_lo));
        chk("ext addr", {7'h0, r[24:0] & amask(k[1:0])}, {7'h0, a_ext});
        if (w) chk("write data", d & 32'hffff, wr_seen & 32'hffff);
      end
    end
    for (int i = 0; i < 3; i++) begin
      z = (i == 2) ? SIZE_4 : 2'(i);
      cfg(3'h5, {16'h0006, z[1], 3'h1, 2'h3, z | SIZE_2, 8'h0c});
      d = rnd();
      r = rnd();
      acc(1'b1, 3'h5, z);
      chk("swap write", bsw(d, z), wr_seen & bsw(32'hffff_ffff, z));
      rd_word <= rnd();
      acc(1'b0, 3'h5, z);
      chk("swap read", bsw(rd_word, z), a_q & bsw(32'hffff_ffff, z));
    end
    ack_after <= 8'h05;
    for (int i = 0; i < 4; i++) begin
      e = rnd();
      cfg(3'h2, {16'h0014, 1'b1, i[1:0], 1'b1, 2'h3, SIZE_2, e[1:0], 6'h00});
      r = rnd();
      acc(1'b0, 3'h2, SIZE_2);
      chk("latch span", {31'h0, i[1]} + 32'h1, 32'(a_ls));
      a_q = latch_seen & 32'h07ff_ffff;
      chk("addr tenure", {5'h0, e[1:0], r[24:0]}, a_q);
      chk("early end", {31'h0, i[0]}, {31'h0, a_lo < 20});
    end
    ack_after <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      e = rnd();
      s = 3'(1 + e % 5);
      reg_op(1'b1, OFS_CONTROL, {i[1], 6'h00, 1'b1, 24'h00_0000});
      cfg(s, {16'h0004, 4'h1, 10'h000, ~i[0], i[0]});
      acc(i[0], s, SIZE_1);
      chk("denied span", 32'h0000_0000, 32'(a_lo));
      chk("denied error", {31'h0, i[1]}, {31'h0, a_e});
      reg_c(OFS_STATUS, {2'h0, ~i[0], i[0], 1'b0, s, 24'h00_0000});
      reg_op(1'b1, OFS_STATUS, 32'h3000_0000);
      reg_c(OFS_STATUS, {5'h00, s, 24'h00_0000});
    end
    reg_op(1'b1, OFS_CONTROL, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      cfg(3'(i), 32'h0003_1000);
      acc(1'b1, 3'(i), SIZE_1);
      chk("global gate", (i == 0) ? 32'h3 : 32'h0, 32'(a_lo));
    end
    for (int i = 0; i < 2; i++) begin
      reg_op(1'b1, OFS_CONTROL, {3'h0, i[0], 28'h000_0000});
      reg_op(1'b1, 12'h320, 32'hffff_ffff);
      chk("bad write err", {31'h0, i[0]}, {31'h0, a_e});
      reg_op(1'b0, 12'h000, 32'h0000_0000);
      chk("bad read err", {31'h0, i[0]}, {31'h0, a_e});
      reg_c(OFS_CONTROL, {3'h0, i[0], 28'h000_0000});
      reg_op(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("bad flags", 32'h0003_0000, a_q & 32'h0003_0000);
      reg_op(1'b1, OFS_STATUS, 32'h0003_0000);
      reg_c(OFS_STATUS, {5'h00, s, 24'h00_0000});
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
